// *** rtl/flash_rewrite_control.sv ***
`timescale 1ns/1ps
module flash_rewrite_control #(
    parameter int NUM_BLOCKS = flash_ctl_pkg::NUM_BLOCKS,
    parameter int BLK_W = $clog2(NUM_BLOCKS)
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic REWRITE_EN_WR,
    input wire logic LOCK_DIS_WR,
    input wire logic STOP_WR,
    input wire logic CTRL_B_WR,
    input wire logic MODE_REG_WR,
    input wire logic WR_VALUE,
    input wire logic MODE_WE_VAL,
    input wire logic DF_WAIT_VAL,
    input wire logic SLOW_READ_VAL,
    input wire logic LOW_CURRENT_VAL,
    input wire logic EW_MODE_VAL,
    input wire logic RSV_EN_VAL,
    input wire logic CMD_VALID,
    input wire flash_ctl_pkg::op_t CMD_OP,
    input wire logic [BLK_W-1:0] CMD_BLOCK,
    input wire logic CORE_DONE,
    input wire logic CORE_FAIL,
    input wire logic NMI,
    input wire logic WDT_IRQ,
    input wire logic WAIT_MODE,
    input wire logic STOP_MODE,
    output logic FLASH_READY,
    output logic PROGRAM_ERROR,
    output logic ERASE_ERROR,
    output logic LOCK_STATUS_RESULT,
    output logic REWRITE_EN,
    output logic LOCK_DIS,
    output logic FLASH_STOP,
    output logic MODE_WE,
    output logic DF_WAIT,
    output logic SLOW_READ,
    output logic LOW_CURRENT_READ,
    output logic EW_MODE,
    output logic RSV_EN,
    output logic WDT_HALT,
    output logic FLASH_POWER_ON,
    output logic FLASH_ACCESS_EN,
    output logic CORE_START,
    output flash_ctl_pkg::op_t CORE_OP,
    output logic [BLK_W-1:0] CORE_BLOCK,
    output logic CORE_ABORT
);
    op_if opi ();

    logic rewrite_en_q, rewrite_en_d;
    logic lock_dis_q, lock_dis_d;
    logic stop_q, stop_d;
    logic en_armed_q, en_armed_d;
    logic dis_armed_q, dis_armed_d;
    logic mode_we_q, mode_we_d;
    logic df_wait_q, df_wait_d;
    logic slow_q, slow_d;
    logic lowcur_q, lowcur_d;
    logic ew_q, ew_d;
    logic rsv_q, rsv_d;
    logic prog_err_q, prog_err_d;
    logic erase_err_q, erase_err_d;
    logic lock_res_q, lock_res_d;
    logic [BLK_W-1:0] blk_q, blk_d;
    logic [NUM_BLOCKS-1:0] lock_q, lock_d;
    logic force_rst, cmd_ok, protected_hit, launch, ref_prog, ref_erase;

    // nmi always, watchdog only in ram-executed mode, forces register reset
    assign force_rst = NMI || (WDT_IRQ && !ew_q);
    // command gate: rewrite enabled, flash running, engine idle
    assign cmd_ok = CMD_VALID && rewrite_en_q && !stop_q && !opi.busy && !force_rst;
    // lock protection applies unless the disable bit is set
    assign protected_hit = !lock_dis_q && (lock_q[CMD_BLOCK] == flash_ctl_pkg::LOCKED);
    assign ref_prog = (CMD_OP == flash_ctl_pkg::OP_PROGRAM) && protected_hit;
    assign ref_erase = (CMD_OP == flash_ctl_pkg::OP_ERASE) && protected_hit;
    assign launch = cmd_ok && (CMD_OP != flash_ctl_pkg::OP_CLEAR_ST) && !ref_prog && !ref_erase;

    assign opi.start = launch;
    assign opi.op = CMD_OP;
    assign opi.abort = force_rst || stop_q;
    assign opi.core_done = CORE_DONE;
    assign opi.core_fail = CORE_FAIL;

    op_engine u_engine (
        .clk(CLK),
        .rst_n(RST_N),
        .opi(opi)
    );

    // control register a: enable bits with the zero-then-one guard
    always_comb begin
        rewrite_en_d = rewrite_en_q;
        lock_dis_d = lock_dis_q;
        stop_d = stop_q;
        en_armed_d = en_armed_q;
        dis_armed_d = dis_armed_q;
        if (REWRITE_EN_WR) begin
            if (!WR_VALUE) begin
                rewrite_en_d = 1'b0;
                en_armed_d = 1'b1;
            end else begin
                rewrite_en_d = en_armed_q ? 1'b1 : rewrite_en_q;
                en_armed_d = 1'b0;
            end
        end
        if (LOCK_DIS_WR) begin
            if (!WR_VALUE) begin
                lock_dis_d = 1'b0;
                dis_armed_d = 1'b1;
            end else begin
                lock_dis_d = dis_armed_q ? 1'b1 : lock_dis_q;
                dis_armed_d = 1'b0;
            end
        end
        if (STOP_WR) begin
            stop_d = WR_VALUE;
        end
        if (force_rst) begin
            rewrite_en_d = flash_ctl_pkg::RST_REWRITE_EN;
            lock_dis_d = flash_ctl_pkg::RST_LOCK_DIS;
            stop_d = flash_ctl_pkg::RST_STOP;
            en_armed_d = 1'b0;
            dis_armed_d = 1'b0;
        end
    end

    // control register b and the mode register
    always_comb begin
        mode_we_d = mode_we_q;
        df_wait_d = df_wait_q;
        slow_d = slow_q;
        lowcur_d = lowcur_q;
        ew_d = ew_q;
        rsv_d = rsv_q;
        if (CTRL_B_WR) begin
            mode_we_d = MODE_WE_VAL;
            df_wait_d = DF_WAIT_VAL;
            slow_d = SLOW_READ_VAL;
            lowcur_d = LOW_CURRENT_VAL;
        end
        if (MODE_REG_WR && mode_we_q) begin
            ew_d = EW_MODE_VAL;
            rsv_d = RSV_EN_VAL;
        end
        if (force_rst) begin
            mode_we_d = flash_ctl_pkg::RST_MODE_WE;
            df_wait_d = flash_ctl_pkg::RST_DF_WAIT;
            slow_d = flash_ctl_pkg::RST_SLOW_READ;
            lowcur_d = flash_ctl_pkg::RST_LOW_CURRENT;
        end
    end

    // status flags, lock result and the lock bit store
    always_comb begin
        prog_err_d = prog_err_q;
        erase_err_d = erase_err_q;
        lock_res_d = lock_res_q;
        blk_d = launch ? CMD_BLOCK : blk_q;
        lock_d = lock_q;
        if (cmd_ok && CMD_OP == flash_ctl_pkg::OP_CLEAR_ST) begin
            prog_err_d = 1'b0;
            erase_err_d = 1'b0;
        end
        if (cmd_ok && ref_prog) begin
            prog_err_d = 1'b1;
        end
        if (cmd_ok && ref_erase) begin
            erase_err_d = 1'b1;
        end
        if (opi.done) begin
            case (opi.op_cur)
                flash_ctl_pkg::OP_PROGRAM: prog_err_d = opi.fail;
                flash_ctl_pkg::OP_ERASE: begin
                    erase_err_d = opi.fail;
                    if (lock_dis_q && !opi.fail) begin
                        lock_d[blk_q] = flash_ctl_pkg::UNLOCKED;
                    end
                end
                flash_ctl_pkg::OP_BLANK: erase_err_d = opi.fail;
                flash_ctl_pkg::OP_LOCK_PROG: begin
                    if (!opi.fail) begin
                        lock_d[blk_q] = flash_ctl_pkg::LOCKED;
                    end
                    prog_err_d = opi.fail;
                end
                flash_ctl_pkg::OP_LOCK_READ: lock_res_d = lock_q[blk_q];
                default: lock_res_d = lock_res_q;
            endcase
        end
        if (force_rst) begin
            prog_err_d = flash_ctl_pkg::RST_PROG_ERR;
            erase_err_d = flash_ctl_pkg::RST_ERASE_ERR;
            lock_res_d = flash_ctl_pkg::RST_LOCK_RESULT;
        end
    end

    // register all state
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rewrite_en_q <= flash_ctl_pkg::RST_REWRITE_EN;
            lock_dis_q <= flash_ctl_pkg::RST_LOCK_DIS;
            stop_q <= flash_ctl_pkg::RST_STOP;
            en_armed_q <= 1'b0;
            dis_armed_q <= 1'b0;
            mode_we_q <= flash_ctl_pkg::RST_MODE_WE;
            df_wait_q <= flash_ctl_pkg::RST_DF_WAIT;
            slow_q <= flash_ctl_pkg::RST_SLOW_READ;
            lowcur_q <= flash_ctl_pkg::RST_LOW_CURRENT;
            ew_q <= flash_ctl_pkg::RST_EW_MODE;
            rsv_q <= flash_ctl_pkg::RST_RSV_EN;
            prog_err_q <= flash_ctl_pkg::RST_PROG_ERR;
            erase_err_q <= flash_ctl_pkg::RST_ERASE_ERR;
            lock_res_q <= flash_ctl_pkg::RST_LOCK_RESULT;
            blk_q <= '0;
            lock_q <= {NUM_BLOCKS{flash_ctl_pkg::RST_LOCK_BIT}};
        end else begin
            rewrite_en_q <= rewrite_en_d;
            lock_dis_q <= lock_dis_d;
            stop_q <= stop_d;
            en_armed_q <= en_armed_d;
            dis_armed_q <= dis_armed_d;
            mode_we_q <= mode_we_d;
            df_wait_q <= df_wait_d;
            slow_q <= slow_d;
            lowcur_q <= lowcur_d;
            ew_q <= ew_d;
            rsv_q <= rsv_d;
            prog_err_q <= prog_err_d;
            erase_err_q <= erase_err_d;
            lock_res_q <= lock_res_d;
            blk_q <= blk_d;
            lock_q <= lock_d;
        end
    end

    // outputs
    assign FLASH_READY = !opi.busy;
    assign PROGRAM_ERROR = prog_err_q;
    assign ERASE_ERROR = erase_err_q;
    assign LOCK_STATUS_RESULT = lock_res_q;
    assign REWRITE_EN = rewrite_en_q;
    assign LOCK_DIS = lock_dis_q;
    assign FLASH_STOP = stop_q;
    assign MODE_WE = mode_we_q;
    assign DF_WAIT = df_wait_q;
    assign SLOW_READ = slow_q;
    assign LOW_CURRENT_READ = slow_q && lowcur_q;
    assign EW_MODE = ew_q;
    assign RSV_EN = rsv_q;
    assign WDT_HALT = ew_q && opi.busy && (opi.op_cur == flash_ctl_pkg::OP_PROGRAM
        || opi.op_cur == flash_ctl_pkg::OP_ERASE);
    assign FLASH_POWER_ON = !stop_q && !WAIT_MODE && !STOP_MODE;
    assign FLASH_ACCESS_EN = !stop_q;
    assign CORE_START = opi.core_start;
    assign CORE_OP = opi.op_cur;
    assign CORE_BLOCK = blk_q;
    assign CORE_ABORT = opi.abort && opi.busy;

    sequence s_zero_write;
        LOCK_DIS_WR && !WR_VALUE && !force_rst;
    endsequence
    sequence s_one_write;
        LOCK_DIS_WR && WR_VALUE && !force_rst;
    endsequence

    a_ready_busy: assert property (@(posedge CLK) disable iff (!RST_N)
        launch |=> !FLASH_READY)
        else $error("ready flag high after launch");
    a_cmd_gate: assert property (@(posedge CLK) disable iff (!RST_N)
        CORE_START |-> rewrite_en_q && !stop_q)
        else $error("command started without rewrite enable");
    a_dis_seq: assert property (@(posedge CLK) disable iff (!RST_N)
        s_zero_write ##1 (!LOCK_DIS_WR && !force_rst) ##1 s_one_write |=> LOCK_DIS)
        else $error("lock disable not set after zero then one");
    a_unlock_erase: assert property (@(posedge CLK) disable iff (!RST_N)
        opi.done && opi.op_cur == flash_ctl_pkg::OP_ERASE && lock_dis_q && !opi.fail
        |=> lock_q[$past(blk_q)] == flash_ctl_pkg::UNLOCKED)
        else $error("erased block not unlocked");
    a_stop_power: assert property (@(posedge CLK) disable iff (!RST_N)
        stop_q |-> !FLASH_POWER_ON && !FLASH_ACCESS_EN && !CORE_START)
        else $error("flash active while stopped");
    a_sleep_power: assert property (@(posedge CLK) disable iff (!RST_N)
        (WAIT_MODE || STOP_MODE) |-> !FLASH_POWER_ON)
        else $error("flash powered in sleep mode");
    a_prog_err: assert property (@(posedge CLK) disable iff (!RST_N)
        opi.done && opi.op_cur == flash_ctl_pkg::OP_PROGRAM && !force_rst
        |=> PROGRAM_ERROR == $past(opi.fail))
        else $error("program error flag wrong");
    a_mode_lock: assert property (@(posedge CLK) disable iff (!RST_N)
        !mode_we_q |=> $stable(EW_MODE) && $stable(RSV_EN))
        else $error("mode register changed while write locked");
    a_lock_result: assert property (@(posedge CLK) disable iff (!RST_N)
        opi.done && opi.op_cur == flash_ctl_pkg::OP_LOCK_READ && !force_rst
        |=> LOCK_STATUS_RESULT == $past(lock_q[blk_q]))
        else $error("lock result mismatch");
    a_lowcur_gate: assert property (@(posedge CLK) disable iff (!RST_N)
        LOW_CURRENT_READ |-> SLOW_READ)
        else $error("low current read without slow read");
    a_force_reset: assert property (@(posedge CLK) disable iff (!RST_N)
        force_rst |=> !REWRITE_EN && !LOCK_DIS && !PROGRAM_ERROR && !ERASE_ERROR && FLASH_READY)
        else $error("forced reset incomplete");
    a_wdt_halt: assert property (@(posedge CLK) disable iff (!RST_N)
        WDT_HALT |-> EW_MODE && !FLASH_READY)
        else $error("watchdog halted outside ew1 operation");
    a_clear_st: assert property (@(posedge CLK) disable iff (!RST_N)
        cmd_ok && CMD_OP == flash_ctl_pkg::OP_CLEAR_ST && !opi.done
        |=> !PROGRAM_ERROR && !ERASE_ERROR)
        else $error("clear status left an error flag");
endmodule : flash_rewrite_control

// *** pkg/flash_ctl_pkg.sv ***
package flash_ctl_pkg;
    // software command kinds seen by the control logic
    typedef enum logic [2:0] {
        OP_PROGRAM   = 3'h0,
        OP_ERASE     = 3'h1,
        OP_LOCK_PROG = 3'h2,
        OP_LOCK_READ = 3'h3,
        OP_BLANK     = 3'h4,
        OP_CLEAR_ST  = 3'h5
    } op_t;

    // engine states, one-hot
    typedef enum logic [1:0] {
        ENG_IDLE = 2'h1,
        ENG_RUN  = 2'h2
    } eng_state_t;

    // reset values of the control bits
    localparam logic RST_REWRITE_EN = 1'h0;
    localparam logic RST_LOCK_DIS = 1'h0;
    localparam logic RST_STOP = 1'h0;
    localparam logic RST_MODE_WE = 1'h0;
    localparam logic RST_DF_WAIT = 1'h0;
    localparam logic RST_SLOW_READ = 1'h0;
    localparam logic RST_LOW_CURRENT = 1'h0;
    localparam logic RST_EW_MODE = 1'h0;
    localparam logic RST_RSV_EN = 1'h0;
    localparam logic RST_PROG_ERR = 1'h0;
    localparam logic RST_ERASE_ERR = 1'h0;
    localparam logic RST_LOCK_RESULT = 1'h1;
    localparam logic RST_LOCK_BIT = 1'h1; // unlocked
    localparam logic LOCKED = 1'h0;
    localparam logic UNLOCKED = 1'h1;
    localparam int NUM_BLOCKS = 8;
endpackage : flash_ctl_pkg

// *** pkg/op_if.sv ***
`timescale 1ns/1ps
interface op_if;
    logic start;
    flash_ctl_pkg::op_t op;
    logic abort;
    logic busy;
    logic done;
    logic fail;
    flash_ctl_pkg::op_t op_cur;
    logic core_start;
    logic core_done;
    logic core_fail;

    modport ctl (output start, output op, output abort, output core_done, output core_fail,
        input busy, input done, input fail, input op_cur, input core_start);
    modport eng (input start, input op, input abort, input core_done, input core_fail,
        output busy, output done, output fail, output op_cur, output core_start);
endinterface : op_if

// *** rtl/op_engine.sv ***
`timescale 1ns/1ps
module op_engine (
    input wire logic clk,
    input wire logic rst_n,
    op_if.eng opi
);
    flash_ctl_pkg::eng_state_t state_q, state_d;
    flash_ctl_pkg::op_t op_q, op_d;
    logic done_q, done_d;
    logic fail_q, fail_d;

    // next state: idle takes a start, run waits for the core or an abort
    always_comb begin
        state_d = state_q;
        op_d = op_q;
        done_d = 1'b0;
        fail_d = fail_q;
        case (state_q)
            flash_ctl_pkg::ENG_IDLE: begin
                if (opi.start && !opi.abort) begin
                    state_d = flash_ctl_pkg::ENG_RUN;
                    op_d = opi.op;
                end
            end
            flash_ctl_pkg::ENG_RUN: begin
                if (opi.abort) begin
                    state_d = flash_ctl_pkg::ENG_IDLE;
                end else if (opi.core_done) begin
                    state_d = flash_ctl_pkg::ENG_IDLE;
                    done_d = 1'b1;
                    fail_d = opi.core_fail;
                end
            end
            default: state_d = flash_ctl_pkg::ENG_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= flash_ctl_pkg::ENG_IDLE;
            op_q <= flash_ctl_pkg::OP_PROGRAM;
            done_q <= 1'b0;
            fail_q <= 1'b0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            done_q <= done_d;
            fail_q <= fail_d;
        end
    end

    assign opi.busy = (state_q == flash_ctl_pkg::ENG_RUN);
    assign opi.done = done_q;
    assign opi.fail = fail_q;
    assign opi.op_cur = op_q;
    assign opi.core_start = opi.start && !opi.abort && (state_q == flash_ctl_pkg::ENG_IDLE);

    // an abort always returns the engine to idle on the next edge
    a_abort_to_idle: assert property (@(posedge clk) disable iff (!rst_n)
        opi.abort |=> !opi.busy && !opi.done)
        else $error("engine still busy after abort");
endmodule : op_engine

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
    logic CLK, RST_N, REWRITE_EN_WR, LOCK_DIS_WR, STOP_WR, CTRL_B_WR, MODE_REG_WR, WR_VALUE;
    logic MODE_WE_VAL, DF_WAIT_VAL, SLOW_READ_VAL, LOW_CURRENT_VAL, EW_MODE_VAL, RSV_EN_VAL;
    logic CMD_VALID, CORE_DONE, CORE_FAIL, NMI, WDT_IRQ, WAIT_MODE, STOP_MODE;
    flash_ctl_pkg::op_t CMD_OP;
    logic [2:0] CMD_BLOCK;
    logic FLASH_READY, PROGRAM_ERROR, ERASE_ERROR, LOCK_STATUS_RESULT, REWRITE_EN, LOCK_DIS;
    logic FLASH_STOP, MODE_WE, DF_WAIT, SLOW_READ, LOW_CURRENT_READ, EW_MODE, RSV_EN, WDT_HALT;
    logic FLASH_POWER_ON, FLASH_ACCESS_EN, CORE_START, CORE_ABORT;
    flash_ctl_pkg::op_t CORE_OP;
    logic [2:0] CORE_BLOCK;
    int fails = 0;
    int compares = 0;
    localparam int SETTLE_CYCLES = 4; // flash settling wait after a stop bit change

    flash_rewrite_control i_dut (.CLK(CLK), .RST_N(RST_N), .REWRITE_EN_WR(REWRITE_EN_WR),
        .LOCK_DIS_WR(LOCK_DIS_WR), .STOP_WR(STOP_WR), .CTRL_B_WR(CTRL_B_WR),
        .MODE_REG_WR(MODE_REG_WR), .WR_VALUE(WR_VALUE), .MODE_WE_VAL(MODE_WE_VAL),
        .DF_WAIT_VAL(DF_WAIT_VAL), .SLOW_READ_VAL(SLOW_READ_VAL),
        .LOW_CURRENT_VAL(LOW_CURRENT_VAL), .EW_MODE_VAL(EW_MODE_VAL), .RSV_EN_VAL(RSV_EN_VAL),
        .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP), .CMD_BLOCK(CMD_BLOCK), .CORE_DONE(CORE_DONE),
        .CORE_FAIL(CORE_FAIL), .NMI(NMI), .WDT_IRQ(WDT_IRQ), .WAIT_MODE(WAIT_MODE),
        .STOP_MODE(STOP_MODE), .FLASH_READY(FLASH_READY), .PROGRAM_ERROR(PROGRAM_ERROR),
        .ERASE_ERROR(ERASE_ERROR), .LOCK_STATUS_RESULT(LOCK_STATUS_RESULT),
        .REWRITE_EN(REWRITE_EN), .LOCK_DIS(LOCK_DIS), .FLASH_STOP(FLASH_STOP),
        .MODE_WE(MODE_WE), .DF_WAIT(DF_WAIT), .SLOW_READ(SLOW_READ),
        .LOW_CURRENT_READ(LOW_CURRENT_READ), .EW_MODE(EW_MODE), .RSV_EN(RSV_EN),
        .WDT_HALT(WDT_HALT), .FLASH_POWER_ON(FLASH_POWER_ON),
        .FLASH_ACCESS_EN(FLASH_ACCESS_EN), .CORE_START(CORE_START), .CORE_OP(CORE_OP),
        .CORE_BLOCK(CORE_BLOCK), .CORE_ABORT(CORE_ABORT));

    // 40 MHz clock
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end

    // compare one observed value with its expectation
    task automatic chk(input string name, input logic [3:0] seen, input logic [3:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic end_sim;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    // one strobe cycle on a control bit: 0 rewrite enable, 1 lock disable, 2 stop
    task automatic wr(input int sel, input logic v);
        WR_VALUE = v;
        REWRITE_EN_WR = (sel == 0);
        LOCK_DIS_WR = (sel == 1);
        STOP_WR = (sel == 2);
        @(negedge CLK);
        {REWRITE_EN_WR, LOCK_DIS_WR, STOP_WR} = 3'h0;
        @(negedge CLK);
    endtask : wr

    // zero-then-one sequence that sets a protected bit
    task automatic set01(input int sel);
        wr(sel, 1'b0);
        wr(sel, 1'b1);
    endtask : set01

    // control register b load: mode write enable, data flash wait, slow read, low current
    task automatic ctrl_b(input logic [3:0] v);
        {MODE_WE_VAL, DF_WAIT_VAL, SLOW_READ_VAL, LOW_CURRENT_VAL} = v;
        CTRL_B_WR = 1'b1;
        @(negedge CLK);
        CTRL_B_WR = 1'b0;
        @(negedge CLK);
    endtask : ctrl_b

    task automatic mode_wr(input logic ew, input logic rsv);
        {EW_MODE_VAL, RSV_EN_VAL} = {ew, rsv};
        MODE_REG_WR = 1'b1;
        @(negedge CLK);
        MODE_REG_WR = 1'b0;
        @(negedge CLK);
    endtask : mode_wr

    // issue a command and check whether the core is started in the same cycle
    task automatic cmd(input flash_ctl_pkg::op_t op, input logic [2:0] blk, input logic go);
        CMD_OP = op;
        CMD_BLOCK = blk;
        CMD_VALID = 1'b1;
        #1;
        chk("core_start", {3'h0, CORE_START}, {3'h0, go});
        @(negedge CLK);
        CMD_VALID = 1'b0;
        chk("ready", {3'h0, FLASH_READY}, {3'h0, ~go});
        if (go) begin
            chk("core_op", {1'b0, CORE_OP}, {1'b0, op});
            chk("core_block", {1'b0, CORE_BLOCK}, {1'b0, blk});
        end
        @(negedge CLK);
    endtask : cmd

    // flash core reports the end of the running operation
    task automatic finish(input logic f);
        CORE_DONE = 1'b1;
        CORE_FAIL = f;
        @(negedge CLK);
        {CORE_DONE, CORE_FAIL} = 2'h0;
        @(negedge CLK);
        chk("ready_end", {3'h0, FLASH_READY}, 4'h1);
    endtask : finish

    // pulse one of the forced-reset sources while an operation runs
    task automatic force_pulse(input logic nmi_v, input logic exp_abort);
        {NMI, WDT_IRQ} = {nmi_v, ~nmi_v};
        #1;
        chk("core_abort", {3'h0, CORE_ABORT}, {3'h0, exp_abort});
        @(negedge CLK);
        {NMI, WDT_IRQ} = 2'h0;
        @(negedge CLK);
    endtask : force_pulse

    // watchdog against a hang
    initial begin
        repeat (3000) @(posedge CLK);
        fails++;
        end_sim();
    end

    initial begin
        RST_N = 1'b0;
        {REWRITE_EN_WR, LOCK_DIS_WR, STOP_WR, CTRL_B_WR, MODE_REG_WR, WR_VALUE} = 6'h00;
        {MODE_WE_VAL, DF_WAIT_VAL, SLOW_READ_VAL, LOW_CURRENT_VAL, EW_MODE_VAL} = 5'h00;
        {RSV_EN_VAL, CMD_VALID, CORE_DONE, CORE_FAIL, NMI, WDT_IRQ} = 6'h00;
        {WAIT_MODE, STOP_MODE} = 2'h0;
        CMD_OP = flash_ctl_pkg::OP_PROGRAM;
        CMD_BLOCK = 3'h0;
        repeat (12) @(negedge CLK);
        RST_N = 1'b1;
        chk("reset_ready", {3'h0, FLASH_READY}, 4'h1);
        chk("reset_lock_result", {3'h0, LOCK_STATUS_RESULT}, 4'h1);
        chk("reset_power", {2'h0, FLASH_POWER_ON, FLASH_ACCESS_EN}, 4'h3);
        // reserved enable set and ram execution chosen before any rewrite
        ctrl_b(4'h8);
        mode_wr(1'b0, 1'b1);
        chk("rsv_set", {2'h0, EW_MODE, RSV_EN}, 4'h1);
        // a one without a preceding zero is ignored, so commands stay refused
        wr(0, 1'b1);
        chk("rewrite_en", {3'h0, REWRITE_EN}, 4'h0);
        cmd(flash_ctl_pkg::OP_PROGRAM, 3'h1, 1'b0);
        set01(0);
        chk("rewrite_en", {3'h0, REWRITE_EN}, 4'h1);
        // failing program, then failing blank check
        cmd(flash_ctl_pkg::OP_PROGRAM, 3'h1, 1'b1);
        finish(1'b1);
        chk("prog_err", {2'h0, PROGRAM_ERROR, ERASE_ERROR}, 4'h2);
        cmd(flash_ctl_pkg::OP_BLANK, 3'h2, 1'b1);
        finish(1'b1);
        chk("erase_err", {2'h0, PROGRAM_ERROR, ERASE_ERROR}, 4'h3);
        cmd(flash_ctl_pkg::OP_CLEAR_ST, 3'h0, 1'b0);
        chk("clear_status", {2'h0, PROGRAM_ERROR, ERASE_ERROR}, 4'h0);
        // lock block 3, read it back, then a program there is refused
        cmd(flash_ctl_pkg::OP_LOCK_PROG, 3'h3, 1'b1);
        finish(1'b0);
        cmd(flash_ctl_pkg::OP_LOCK_READ, 3'h3, 1'b1);
        finish(1'b0);
        chk("lock_result", {3'h0, LOCK_STATUS_RESULT}, 4'h0);
        cmd(flash_ctl_pkg::OP_PROGRAM, 3'h3, 1'b0);
        chk("locked_prog_err", {3'h0, PROGRAM_ERROR}, 4'h1);
        cmd(flash_ctl_pkg::OP_CLEAR_ST, 3'h0, 1'b0);
        // lock disable keeps the stored state but lets an erase through and unlocks
        set01(1);
        chk("lock_dis", {3'h0, LOCK_DIS}, 4'h1);
        cmd(flash_ctl_pkg::OP_LOCK_READ, 3'h3, 1'b1);
        finish(1'b0);
        chk("lock_kept", {3'h0, LOCK_STATUS_RESULT}, 4'h0);
        cmd(flash_ctl_pkg::OP_ERASE, 3'h3, 1'b1);
        finish(1'b0);
        chk("erase_ok", {3'h0, ERASE_ERROR}, 4'h0);
        cmd(flash_ctl_pkg::OP_LOCK_READ, 3'h3, 1'b1);
        finish(1'b0);
        chk("unlocked", {3'h0, LOCK_STATUS_RESULT}, 4'h1);
        // watchdog in ram execution mode aborts and clears the control bits
        cmd(flash_ctl_pkg::OP_PROGRAM, 3'h4, 1'b1);
        chk("no_halt_ew0", {3'h0, WDT_HALT}, 4'h0);
        force_pulse(1'b0, 1'b1);
        chk("wdt_clear", {1'b0, FLASH_READY, REWRITE_EN, LOCK_DIS}, 4'h4);
        // mode register guarded by its write enable
        mode_wr(1'b1, 1'b1);
        chk("mode_blocked", {2'h0, EW_MODE, RSV_EN}, 4'h1);
        ctrl_b(4'hD);
        chk("df_wait", {3'h0, DF_WAIT}, 4'h1);
        chk("low_current_off", {3'h0, LOW_CURRENT_READ}, 4'h0);
        ctrl_b(4'hB);
        chk("low_current_on", {2'h0, SLOW_READ, LOW_CURRENT_READ}, 4'h3);
        chk("df_wait_off", {3'h0, DF_WAIT}, 4'h0);
        mode_wr(1'b1, 1'b1);
        chk("mode_written", {2'h0, EW_MODE, RSV_EN}, 4'h3);
        // flash execution mode: watchdog halts, watchdog irq ignored, nmi aborts
        ctrl_b(4'hC);
        set01(0);
        cmd(flash_ctl_pkg::OP_ERASE, 3'h5, 1'b1);
        chk("wdt_halt", {3'h0, WDT_HALT}, 4'h1);
        force_pulse(1'b0, 1'b0);
        chk("still_busy", {2'h0, FLASH_READY, REWRITE_EN}, 4'h1);
        force_pulse(1'b1, 1'b1);
        chk("nmi_clear", {FLASH_READY, REWRITE_EN, MODE_WE, DF_WAIT}, 4'h8);
        chk("mode_kept", {3'h0, EW_MODE}, 4'h1);
        // wait and stop mode power the array down without touching the bits
        wr(0, 1'b0);
        WAIT_MODE = 1'b1;
        #1;
        chk("wait_power", {2'h0, FLASH_POWER_ON, FLASH_ACCESS_EN}, 4'h1);
        @(negedge CLK);
        {WAIT_MODE, STOP_MODE} = 2'h1;
        #1;
        chk("stop_power", {2'h0, FLASH_POWER_ON, EW_MODE}, 4'h1);
        @(negedge CLK);
        STOP_MODE = 1'b0;
        #1;
        chk("wake_power", {3'h0, FLASH_POWER_ON}, 4'h1);
        @(negedge CLK);
        // stop bit blocks access and commands until cleared
        set01(0);
        wr(2, 1'b1);
        repeat (SETTLE_CYCLES) @(negedge CLK);
        chk("stop_bit", {1'b0, FLASH_STOP, FLASH_POWER_ON, FLASH_ACCESS_EN}, 4'h4);
        cmd(flash_ctl_pkg::OP_PROGRAM, 3'h6, 1'b0);
        wr(2, 1'b0);
        repeat (SETTLE_CYCLES) @(negedge CLK);
        chk("restart", {1'b0, FLASH_STOP, FLASH_POWER_ON, FLASH_ACCESS_EN}, 4'h3);
        end_sim();
    end
endmodule : tb
